// ===== bench/lacc_host_model.sv
/* Host and smart battery model on the register port of lacc_top.
   Assumes the bench calls its tasks; strobes last one clock cycle. */
`default_nettype none
module lacc_host_model (
    // Clock
    input wire logic clk_in,
    // Register port
    output var logic [7:0] addr_out,
    output var logic [15:0] wdata_out,
    output var logic wr_out,
    output var logic rd_out,
    input wire logic [15:0] rdata_in
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        addr_out = 8'h00;
        wdata_out = 16'h0000;
        wr_out = 1'b0;
        rd_out = 1'b0;
    end
    // Host command or battery message, one strobe cycle
    task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_in);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= 1'b1;
        @(posedge clk_in);
        wr_out <= 1'b0;
        wdata_out <= ~d;
    endtask
    // Read data taken at the edge that closes the answer cycle
    task automatic bus_rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge clk_in);
        rd_out <= 1'b0;
        @(posedge clk_in);
        d = rdata_in;
    endtask
endmodule
`default_nettype wire

// ===== bench/lacc_top_monitor.sv
/* Port checker for lacc_top, bound to every instance.
   Assumes pin changes reach the outputs within five clock edges. */
`default_nettype none
`include "lacc_defines.vh"
module lacc_monitor (
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    // Register port
    input wire logic [7:0] ADDR_IN,
    input wire logic [15:0] WDATA_IN,
    input wire logic WR_IN,
    // Pins
    input wire logic [1:0] CELL_COUNT_SELECT_IN,
    input wire logic SHUTDOWN_INPUT_IN,
    input wire logic SUPPLY_PRESENCE_SENSE_IN,
    input wire logic BATTERY_OVERVOLTAGE_FLAG_IN,
    input wire logic THERM_HOT_IN,
    input wire logic THERM_OVER_RANGE_IN,
    // Outputs
    input wire logic CHARGE_CURRENT_EN_OUT,
    input wire logic SWITCHING_EN_OUT,
    input wire logic DISCHARGE_EN_OUT,
    input wire logic [15:0] FLOAT_TARGET_MV_OUT,
    input wire logic CHARGE_ACTIVE_N_OUT
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking mon_cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    wire ctl_wr = WR_IN && ADDR_IN == `LACC_ADDR_BACKUP_CTRL;
    wire cal_wr = ctl_wr && WDATA_IN[`LACC_CTL_CAL_START];
    wire inh_wr = ctl_wr && WDATA_IN[`LACC_CTL_INHIBIT] && !cal_wr;
    wire [15:0] tgt = CELL_COUNT_SELECT_IN == 2'd0 ? `LACC_FLOAT_2C :
        CELL_COUNT_SELECT_IN == 2'd1 ? `LACC_FLOAT_3C :
        CELL_COUNT_SELECT_IN == 2'd2 ? `LACC_FLOAT_5C : `LACC_FLOAT_6C;
    sequence sel_steady; $stable(CELL_COUNT_SELECT_IN)[*8]; endsequence
    sequence shutdown_input_held; SHUTDOWN_INPUT_IN[*8]; endsequence
    sequence hot_held; THERM_HOT_IN[*8]; endsequence
    sequence supply_gone; (!SUPPLY_PRESENCE_SENSE_IN)[*8]; endsequence
    sequence absent_held; THERM_OVER_RANGE_IN[*8]; endsequence
    sequence ov_held; BATTERY_OVERVOLTAGE_FLAG_IN[*8]; endsequence
    float_target_a: assert property (sel_steady |-> FLOAT_TARGET_MV_OUT == tgt)
        else $error("float target does not match cell count");
    inhibit_stop_a: assert property (
        inh_wr |-> ##3 (CHARGE_ACTIVE_N_OUT && !CHARGE_CURRENT_EN_OUT))
        else $error("charge kept on after inhibit write");
    cal_cause_a: assert property (
        $rose(DISCHARGE_EN_OUT) |-> $past(cal_wr) || $past(cal_wr, 2) || $past(cal_wr, 3))
        else $error("discharge began without a start write");
    shutdown_input_refuse_a: assert property (shutdown_input_held |-> !DISCHARGE_EN_OUT)
        else $error("discharge while shut down");
    hot_halt_a: assert property (hot_held |-> !CHARGE_CURRENT_EN_OUT)
        else $error("charge current on while hot");
    supply_loss_a: assert property (
        supply_gone |-> CHARGE_ACTIVE_N_OUT && !CHARGE_CURRENT_EN_OUT)
        else $error("charging without supply");
    absent_off_a: assert property (absent_held |-> CHARGE_ACTIVE_N_OUT)
        else $error("charge active with battery absent");
    ov_pause_a: assert property (
        ov_held |-> !SWITCHING_EN_OUT || DISCHARGE_EN_OUT)
        else $error("switching during overvoltage");
endmodule
bind lacc_top lacc_monitor u_mon (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN),
    .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN),
    .CELL_COUNT_SELECT_IN(CELL_COUNT_SELECT_IN), .SHUTDOWN_INPUT_IN(SHUTDOWN_INPUT_IN),
    .SUPPLY_PRESENCE_SENSE_IN(SUPPLY_PRESENCE_SENSE_IN),
    .BATTERY_OVERVOLTAGE_FLAG_IN(BATTERY_OVERVOLTAGE_FLAG_IN),
    .THERM_HOT_IN(THERM_HOT_IN), .THERM_OVER_RANGE_IN(THERM_OVER_RANGE_IN),
    .CHARGE_CURRENT_EN_OUT(CHARGE_CURRENT_EN_OUT), .SWITCHING_EN_OUT(SWITCHING_EN_OUT),
    .DISCHARGE_EN_OUT(DISCHARGE_EN_OUT), .FLOAT_TARGET_MV_OUT(FLOAT_TARGET_MV_OUT),
    .CHARGE_ACTIVE_N_OUT(CHARGE_ACTIVE_N_OUT));
`default_nettype wire

// ===== bench/lacc_top_tb.sv
/* Self-checking bench for lacc_top against a model of the charge rules.
   Assumes the host model and checker are compiled before it. */
`default_nettype none
`include "lacc_defines.vh"
module lacc_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] sel = 2'b00;
    // Stop pins: shutdown, no supply, undervoltage, over-range, lockout
    logic [4:0] stp = 5'b00010;
    logic ov = 1'b0, flt = 1'b0, hot = 1'b0, cold = 1'b0, cut = 1'b0, bkd = 1'b0, ar = 1'b0;
    logic [7:0] addr;
    logic [15:0] wdata, rdata, ftgt, cco, s;
    logic wr, rd, ich, sw, dis, act_n, p3, p3oe;
    logic [15:0] rnd = 16'd33525;
    int bad_count = 0, check_count = 0, cyc = 0;
    int m_on = 0, m_ph = 0, m_flt = 0, m_ainh = 0, m_abs = 0, m_ov = 0;
    int m_cal = 0, m_cdone = 0, m_cflt = 0, m_p3 = 0, m_cut = 1930;
    int tg[4] = '{4700, 7050, 11750, 14100};
    int nc[4] = '{2, 3, 5, 6};

    always #25 clk = ~clk;

    lacc_host_model u_host (.clk_in(clk), .addr_out(addr), .wdata_out(wdata), .wr_out(wr),
        .rd_out(rd), .rdata_in(rdata));
    lacc_top u_dut (.CLK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata),
        .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .CELL_COUNT_SELECT_IN(sel),
        .SHUTDOWN_INPUT_IN(stp[0]), .SUPPLY_PRESENCE_SENSE_IN(!stp[1]),
        .SUPPLY_ABOVE_UVLO_IN(!stp[4]), .BATTERY_OVERVOLTAGE_FLAG_IN(ov),
        .BATTERY_UNDERVOLTAGE_FLAG_IN(stp[2]), .BATTERY_AT_FLOAT_IN(flt),
        .AUTO_RESTART_CONDITION_IN(ar), .THERM_HOT_IN(hot), .THERM_COLD_IN(cold),
        .THERM_OVER_RANGE_IN(stp[3]), .THERMISTOR_UNDER_RANGE_IN(1'b0),
        .CUTOFF_REACHED_IN(cut), .BACKDRIVE_FAULT_IN(bkd), .CHARGE_CURRENT_EN_OUT(ich),
        .SWITCHING_EN_OUT(sw), .DISCHARGE_EN_OUT(dis), .FLOAT_TARGET_MV_OUT(ftgt),
        .CAL_CUTOFF_MV_OUT(cco), .CHARGE_ACTIVE_N_OUT(act_n), .STATUS_PIN_THREE_OUT(p3),
        .STATUS_PIN_THREE_OE_OUT(p3oe));

    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        lfsr_next = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string m);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask

    // Pins need five edges to reach the outputs
    task automatic settle();
        repeat (8) @(posedge clk);
    endtask

    task automatic check_all();
        u_host.bus_rd(`LACC_ADDR_CHG_STAT, s);
        cmp(s & 16'h00ef, {8'h00, 1'(m_ov), 1'(m_abs), 1'(m_ainh), 1'b0, 1'(m_ph == 2),
            1'(m_ph == 1), 1'(m_flt), 1'(m_on)}, "charger status");
        u_host.bus_rd(`LACC_ADDR_BACKUP_STAT, s);
        cmp(s & 16'h0007, {13'h0, 1'(m_cflt), 1'(m_cdone), 1'(m_cal)}, "backup status");
        cmp({15'h0, act_n}, 16'(m_on == 0), "active pin");
        cmp({15'h0, dis}, 16'(m_cal), "discharge");
        cmp({14'h0, p3, p3oe}, 16'(m_p3 ? m_cdone : (m_flt && m_on)), "pin three");
        cmp(ftgt, 16'(tg[sel]), "float target");
        cmp(cco, 16'(m_cut * nc[sel]), "cutoff");
        if (m_ov == 0) cmp({15'h0, ich}, 16'(m_on && !m_flt), "charge current");
    endtask

    task automatic pair();
        rnd = lfsr_next(rnd);
        u_host.bus_wr(`LACC_ADDR_CHG_VOLT, rnd | 16'h0001);
        rnd = lfsr_next(rnd);
        u_host.bus_wr(`LACC_ADDR_CHG_CURR, rnd | 16'h0001);
        settle();
    endtask

    task automatic ctl(input logic [15:0] d);
        u_host.bus_wr(`LACC_ADDR_BACKUP_CTRL, d);
        settle();
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 12000) begin
            bad_count++;
            print_verdict();
        end
    end

    initial begin
        repeat (4) @(posedge clk);
        cmp({15'h0, act_n}, 16'h0001, "reset pin");
        rst_n <= 1'b1;
        settle();
        check_all();
        u_host.bus_rd(8'h20, s);
        cmp(s, 16'h0000, "unmapped read");
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            sel <= k[1:0];
            settle();
            check_all();
        end
        @(posedge clk);
        stp <= 5'h00;
        cold <= 1'b1;
        settle();
        m_on = 1;
        m_ph = 1;
        check_all();
        @(posedge clk);
        flt <= 1'b1;
        settle();
        m_ph = 2;
        check_all();
        repeat (2000) @(posedge clk);
        check_all();
        for (int k = 3; k >= 0; k--) begin
            @(posedge clk);
            ov <= k[1] & k[0];
            hot <= k[1] & !k[0];
            settle();
            m_ov = (k == 3);
            m_flt = (k == 2);
            check_all();
            cmp({15'h0, sw}, 16'(k < 2), "switching");
        end
        @(posedge clk);
        flt <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            if (k < 2) ctl(16'(1 << k));
            else u_host.bus_wr(`LACC_ADDR_CHG_CURR, 16'h0000);
            settle();
            m_on = 0;
            m_ph = 0;
            check_all();
            ctl(16'h0000);
            pair();
            m_on = 1;
            m_ph = 1;
            check_all();
        end
        for (int b = 12; b < 16; b++) begin
            u_host.bus_wr(`LACC_ADDR_ALARM, 16'(1 << b));
            settle();
            m_on = 0;
            m_ph = 0;
            m_ainh = 1;
            check_all();
            @(posedge clk);
            ar <= 1'b1;
            settle();
            ar <= 1'b0;
            u_host.bus_rd(`LACC_ADDR_CHG_STAT, s);
            cmp({15'h0, s[`LACC_CST_ALM_INH]}, 16'h0000, "alarm flag");
            pair();
            m_on = 1;
            m_ph = 1;
            m_ainh = 0;
            check_all();
        end
        for (int k = 0; k < 5; k++) begin
            @(posedge clk);
            stp <= 5'(1 << k);
            settle();
            m_on = 0;
            m_ph = 0;
            m_abs = (k == 3);
            check_all();
            @(posedge clk);
            stp <= 5'h00;
            settle();
            m_on = 1;
            m_ph = 1;
            m_abs = 0;
            check_all();
        end
        rnd = lfsr_next(rnd);
        m_cut = rnd[11:0] | 12'h001;
        m_p3 = 1;
        u_host.bus_wr(`LACC_ADDR_CONFIG, 16'(m_cut) | 16'h1000);
        ctl(16'h0004);
        m_cal = 1;
        m_on = 0;
        m_ph = 0;
        check_all();
        @(posedge clk);
        cut <= 1'b1;
        settle();
        cut <= 1'b0;
        settle();
        m_cal = 0;
        m_cdone = 1;
        m_on = 1;
        m_ph = 1;
        check_all();
        ctl(16'h0008);
        m_cdone = 0;
        check_all();
        @(posedge clk);
        stp <= 5'h01;
        settle();
        ctl(16'h0004);
        m_on = 0;
        m_ph = 0;
        check_all();
        @(posedge clk);
        stp <= 5'h00;
        settle();
        ctl(16'h0004);
        m_cal = 1;
        check_all();
        @(posedge clk);
        bkd <= 1'b1;
        settle();
        bkd <= 1'b0;
        settle();
        m_cal = 0;
        m_cflt = 1;
        m_on = 1;
        m_ph = 1;
        ctl(16'h0004);
        check_all();
        ctl(16'h0008);
        m_cflt = 0;
        check_all();
        print_verdict();
    end
endmodule
`default_nettype wire

// ===== hw/lacc_defines.vh
/*
 * Constants of the lead-acid charge and calibration controller:
 * register offsets, field positions, reset values and decode values.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef LACC_DEFINES_VH
`define LACC_DEFINES_VH

// Register offsets (byte addresses)
`define LACC_ADDR_BACKUP_CTRL 8'h00
`define LACC_ADDR_BACKUP_STAT 8'h04
`define LACC_ADDR_CHG_STAT 8'h08
`define LACC_ADDR_CHG_VOLT 8'h0c
`define LACC_ADDR_CHG_CURR 8'h10
`define LACC_ADDR_ALARM 8'h14
`define LACC_ADDR_CONFIG 8'h18
`define LACC_ADDR_FLOAT 8'h1c

// Backup control fields
`define LACC_CTL_INHIBIT 0
`define LACC_CTL_ZEROING 1
`define LACC_CTL_CAL_START 2
`define LACC_CTL_CAL_RESET 3
`define LACC_CTL_POR_RESET 4

// Backup status fields
`define LACC_BST_CAL_ON 0
`define LACC_BST_CAL_DONE 1
`define LACC_BST_CAL_FAULT 2

// Charger status fields
`define LACC_CST_ACTIVE 0
`define LACC_CST_FAULT 1
`define LACC_CST_PHASE0 2
`define LACC_CST_PHASE1 3
`define LACC_CST_CHG_INH 4
`define LACC_CST_ALM_INH 5
`define LACC_CST_ABSENT 6
`define LACC_CST_OV_PAUSE 7

// Alarm message bits
`define LACC_ALM_OVER_CHARGED 15
`define LACC_ALM_TERM_CHARGE 14
`define LACC_ALM_RESERVED 13
`define LACC_ALM_OVER_TEMP 12
`define LACC_ALM_TERM_DISCHG 11

// Config fields: cutoff per cell in mV, status pin three mode
`define LACC_CFG_CUTOFF_MSB 11
`define LACC_CFG_PIN3_MODE 12
`define LACC_CUTOFF_RST 12'd1930
`define LACC_CUTOFF_LI_ION 12'd2750
`define LACC_CUTOFF_NICKEL 12'd950

// Float voltage targets in mV for 2, 3, 5, 6 cells
`define LACC_FLOAT_2C 16'd4700
`define LACC_FLOAT_3C 16'd7050
`define LACC_FLOAT_5C 16'd11750
`define LACC_FLOAT_6C 16'd14100

// Charging value reset (nonzero so standalone charge runs)
`define LACC_CHG_VAL_RST 16'hffff

`endif

// ===== hw/lacc_sync.v
/*
 * Three-stage synchroniser for a group of pin levels.
 * A new level is taken once stages two and three agree.
 * Assumes asynchronous inputs and an active-low asynchronous reset.
 */
`default_nettype none

module lacc_sync #(
    parameter WIDTH = 8
) (
    input wire clk_in,
    input wire rst_n_in,
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] level_out
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg s1_reg;
            reg s2_reg;
            reg s3_reg;
            reg level_reg;
            always @(posedge clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    s1_reg <= 1'b0;
                    s2_reg <= 1'b0;
                    s3_reg <= 1'b0;
                    level_reg <= 1'b0;
                end else begin
                    s1_reg <= async_in[i];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    if (s2_reg == s3_reg) begin
                        level_reg <= s3_reg;
                    end
                end
            end
            assign level_out[i] = level_reg;
        end
    endgenerate
endmodule

`default_nettype wire

// ===== hw/lacc_top.v
/*
 * Lead-acid charge state control and calibration start/end control.
 * Holds the software registers, the charge state machine and the
 * calibration sequencing. Assumes analog comparators deliver levels on
 * pins and that the smart battery messages arrive as register writes.
 */
// Our own choices: the register addresses and the address-and-strobe port.
`default_nettype none

module lacc_top (
    // Clock and reset
    input wire CLK_IN,
    input wire RST_N_IN,
    // Register port
    input wire [7:0] ADDR_IN,
    input wire [15:0] WDATA_IN,
    input wire WR_IN,
    input wire RD_IN,
    output reg [15:0] RDATA_OUT,
    // Sensed pins and decoder levels
    input wire [1:0] CELL_COUNT_SELECT_IN,
    input wire SHUTDOWN_INPUT_IN,
    input wire SUPPLY_PRESENCE_SENSE_IN,
    input wire SUPPLY_ABOVE_UVLO_IN,
    input wire BATTERY_OVERVOLTAGE_FLAG_IN,
    input wire BATTERY_UNDERVOLTAGE_FLAG_IN,
    input wire BATTERY_AT_FLOAT_IN,
    input wire AUTO_RESTART_CONDITION_IN,
    input wire THERM_HOT_IN,
    input wire THERM_COLD_IN,
    input wire THERM_OVER_RANGE_IN,
    input wire THERMISTOR_UNDER_RANGE_IN,
    input wire CUTOFF_REACHED_IN,
    input wire BACKDRIVE_FAULT_IN,
    // Power stage controls
    output reg CHARGE_CURRENT_EN_OUT,
    output reg SWITCHING_EN_OUT,
    output reg DISCHARGE_EN_OUT,
    output reg [15:0] FLOAT_TARGET_MV_OUT,
    output reg [15:0] CAL_CUTOFF_MV_OUT,
    // Status pins
    output reg CHARGE_ACTIVE_N_OUT,
    output reg STATUS_PIN_THREE_OUT,
    output reg STATUS_PIN_THREE_OE_OUT
);
`include "lacc_defines.vh"

    localparam [4:0] ST_IDLE = 5'b00001;
    localparam [4:0] ST_BULK = 5'b00010;
    localparam [4:0] ST_FLOAT = 5'b00100;
    localparam [4:0] ST_OFF = 5'b01000;
    localparam [4:0] ST_CAL = 5'b10000;

    // Cell count from the select pins
    function [2:0] cells_of;
        input [1:0] sel;
        begin
            case (sel)
                2'b00: cells_of = 3'd2;
                2'b01: cells_of = 3'd3;
                2'b10: cells_of = 3'd5;
                default: cells_of = 3'd6;
            endcase
        end
    endfunction

    // Float target from the select pins
    function [15:0] float_of;
        input [1:0] sel;
        begin
            case (sel)
                2'b00: float_of = `LACC_FLOAT_2C;
                2'b01: float_of = `LACC_FLOAT_3C;
                2'b10: float_of = `LACC_FLOAT_5C;
                default: float_of = `LACC_FLOAT_6C;
            endcase
        end
    endfunction

    wire [14:0] pins;
    lacc_sync #(
        .WIDTH(15)
    ) u_sync (
        .clk_in(CLK_IN),
        .rst_n_in(RST_N_IN),
        .async_in({CELL_COUNT_SELECT_IN, SHUTDOWN_INPUT_IN, SUPPLY_PRESENCE_SENSE_IN,
            SUPPLY_ABOVE_UVLO_IN, BATTERY_OVERVOLTAGE_FLAG_IN, BATTERY_UNDERVOLTAGE_FLAG_IN,
            BATTERY_AT_FLOAT_IN, AUTO_RESTART_CONDITION_IN, THERM_HOT_IN, THERM_COLD_IN,
            THERM_OVER_RANGE_IN, THERMISTOR_UNDER_RANGE_IN, CUTOFF_REACHED_IN,
            BACKDRIVE_FAULT_IN}),
        .level_out(pins)
    );

    // Synchronised levels
    wire [1:0] cell_count_select = pins[14:13];
    wire shutdown_input = pins[12];
    wire supply_presence_sense = pins[11];
    wire supply_above_uvlo = pins[10];
    wire battery_overvoltage_flag = pins[9];
    wire battery_undervoltage_flag = pins[8];
    wire battery_at_float = pins[7];
    wire auto_restart_condition = pins[6];
    wire therm_hot_raw = pins[5];
    wire thermistor_under_range = pins[2];
    wire therm_over_range = pins[3];
    wire cutoff_reached = pins[1];
    wire backdrive_fault = pins[0];

    reg [4:0] state_reg;
    reg [4:0] state_next;
    reg charge_inhibit_reg;
    reg zeroing_request_bit_reg;
    reg pin3_mode_reg;
    reg [11:0] cutoff_per_cell_reg;
    reg [15:0] chg_volt_reg;
    reg [15:0] chg_curr_reg;
    reg zero_sent_reg;
    reg zero_sent_next;
    reg charge_fault_bit_reg;
    reg charge_inhibited_reg;
    reg charge_inhibited_next;
    reg alarm_inhibited_reg;
    reg alarm_inhibited_next;
    reg cal_on_reg;
    reg cal_done_reg;
    reg cal_done_next;
    reg discharge_test_fault_reg;
    reg discharge_test_fault_next;

    // Register write decode
    wire wr_ctl = WR_IN && (ADDR_IN == `LACC_ADDR_BACKUP_CTRL);
    wire wr_volt = WR_IN && (ADDR_IN == `LACC_ADDR_CHG_VOLT);
    wire wr_curr = WR_IN && (ADDR_IN == `LACC_ADDR_CHG_CURR);
    wire wr_alarm = WR_IN && (ADDR_IN == `LACC_ADDR_ALARM);
    wire wr_cfg = WR_IN && (ADDR_IN == `LACC_ADDR_CONFIG);
    wire cal_start_cmd = wr_ctl && WDATA_IN[`LACC_CTL_CAL_START];
    wire cal_reset_cmd = wr_ctl && WDATA_IN[`LACC_CTL_CAL_RESET];
    wire por_cmd = wr_ctl && WDATA_IN[`LACC_CTL_POR_RESET];
    wire inhibit_now = wr_ctl ? WDATA_IN[`LACC_CTL_INHIBIT] : charge_inhibit_reg;
    wire zeroing_now = wr_ctl ? WDATA_IN[`LACC_CTL_ZEROING] : zeroing_request_bit_reg;

    // Charging value messages
    wire [15:0] volt_now = wr_volt ? WDATA_IN : chg_volt_reg;
    wire [15:0] curr_now = wr_curr ? WDATA_IN : chg_curr_reg;
    wire zero_write = (wr_volt || wr_curr) && (WDATA_IN == 16'h0000);
    wire pair_nonzero = (wr_volt || wr_curr) && (volt_now != 16'h0000) &&
        (curr_now != 16'h0000);

    // Alarm messages
    wire charge_alarm = wr_alarm && (WDATA_IN[`LACC_ALM_OVER_CHARGED] ||
        WDATA_IN[`LACC_ALM_TERM_CHARGE] || WDATA_IN[`LACC_ALM_RESERVED] ||
        WDATA_IN[`LACC_ALM_OVER_TEMP]);
    wire cal_alarm = wr_alarm && (WDATA_IN[`LACC_ALM_OVER_TEMP] ||
        WDATA_IN[`LACC_ALM_RESERVED] || WDATA_IN[`LACC_ALM_TERM_DISCHG]);

    // Thermistor view: cold is never looked at
    wire battery_absent = therm_over_range;
    wire therm_hot = therm_hot_raw && !thermistor_under_range;
    wire supply_ok = supply_presence_sense && supply_above_uvlo;

    // Stop classes
    wire reset_class = !supply_ok || battery_absent || shutdown_input ||
        battery_undervoltage_flag || por_cmd;
    wire off_class = zero_write || zero_sent_reg || zeroing_now || inhibit_now ||
        charge_alarm || alarm_inhibited_reg;
    wire charge_ok = supply_ok && !battery_absent && !shutdown_input &&
        !inhibit_now && !zeroing_now && !zero_sent_next && !alarm_inhibited_next;
    wire cal_allowed = cal_start_cmd && !discharge_test_fault_reg && !shutdown_input &&
        supply_ok && !battery_absent;
    wire cal_fault_evt = therm_hot || battery_absent || !supply_ok || backdrive_fault ||
        cal_alarm;

    always @* begin
        state_next = state_reg;
        cal_done_next = cal_done_reg;
        discharge_test_fault_next = discharge_test_fault_reg;
        zero_sent_next = zero_sent_reg;
        if (zero_write) begin
            zero_sent_next = 1'b1;
        end else if (pair_nonzero) begin
            zero_sent_next = 1'b0;
        end
        charge_inhibited_next = charge_inhibited_reg || inhibit_now;
        alarm_inhibited_next = alarm_inhibited_reg;
        if (auto_restart_condition || pair_nonzero) begin
            alarm_inhibited_next = 1'b0;
        end
        if (charge_alarm) begin
            alarm_inhibited_next = 1'b1;
        end
        if (cal_reset_cmd || por_cmd || shutdown_input) begin
            cal_done_next = 1'b0;
            discharge_test_fault_next = 1'b0;
        end
        case (state_reg)
            ST_IDLE, ST_OFF, ST_BULK, ST_FLOAT: begin
                if (cal_allowed) begin
                    state_next = ST_CAL;
                    cal_done_next = 1'b0;
                end else if (reset_class) begin
                    state_next = ST_IDLE;
                end else if (off_class) begin
                    state_next = ST_OFF;
                end else if (state_reg == ST_BULK && battery_at_float) begin
                    state_next = ST_FLOAT;
                end else if ((state_reg == ST_IDLE || state_reg == ST_OFF) && charge_ok) begin
                    state_next = ST_BULK;
                end
            end
            ST_CAL: begin
                if (cal_reset_cmd) begin
                    state_next = ST_IDLE;
                end else if (cal_fault_evt) begin
                    state_next = ST_IDLE;
                    discharge_test_fault_next = 1'b1;
                end else if (cutoff_reached) begin
                    state_next = ST_IDLE;
                    cal_done_next = 1'b1;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        if (reset_class) begin
            charge_inhibited_next = 1'b0;
            alarm_inhibited_next = 1'b0;
        end
    end

    wire charging_next = (state_next == ST_BULK) || (state_next == ST_FLOAT);

    // Control registers and charge state
    always @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            state_reg <= ST_IDLE;
            charge_inhibit_reg <= 1'b0;
            zeroing_request_bit_reg <= 1'b0;
            pin3_mode_reg <= 1'b0;
            cutoff_per_cell_reg <= `LACC_CUTOFF_RST;
            chg_volt_reg <= `LACC_CHG_VAL_RST;
            chg_curr_reg <= `LACC_CHG_VAL_RST;
            zero_sent_reg <= 1'b0;
            charge_fault_bit_reg <= 1'b0;
            charge_inhibited_reg <= 1'b0;
            alarm_inhibited_reg <= 1'b0;
            cal_on_reg <= 1'b0;
            cal_done_reg <= 1'b0;
            discharge_test_fault_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            charge_inhibit_reg <= por_cmd ? 1'b0 : inhibit_now;
            zeroing_request_bit_reg <= por_cmd ? 1'b0 : zeroing_now;
            if (wr_cfg) begin
                cutoff_per_cell_reg <= WDATA_IN[`LACC_CFG_CUTOFF_MSB:0];
                pin3_mode_reg <= WDATA_IN[`LACC_CFG_PIN3_MODE];
            end
            chg_volt_reg <= volt_now;
            chg_curr_reg <= curr_now;
            zero_sent_reg <= zero_sent_next;
            // Fault bit tracks hot outside calibration; set wins
            if (therm_hot && (state_reg != ST_CAL)) begin
                charge_fault_bit_reg <= 1'b1;
            end else if (!therm_hot) begin
                charge_fault_bit_reg <= 1'b0;
            end
            charge_inhibited_reg <= charge_inhibited_next;
            alarm_inhibited_reg <= alarm_inhibited_next;
            cal_on_reg <= (state_next == ST_CAL);
            cal_done_reg <= cal_done_next;
            discharge_test_fault_reg <= discharge_test_fault_next;
        end
    end

    // Registered outputs
    always @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            CHARGE_CURRENT_EN_OUT <= 1'b0;
            SWITCHING_EN_OUT <= 1'b0;
            DISCHARGE_EN_OUT <= 1'b0;
            FLOAT_TARGET_MV_OUT <= 16'h0000;
            CAL_CUTOFF_MV_OUT <= 16'h0000;
            CHARGE_ACTIVE_N_OUT <= 1'b1;
            STATUS_PIN_THREE_OUT <= 1'b0;
            STATUS_PIN_THREE_OE_OUT <= 1'b0;
        end else begin
            FLOAT_TARGET_MV_OUT <= float_of(cell_count_select);
            CAL_CUTOFF_MV_OUT <= {4'h0, cutoff_per_cell_reg} *
                {13'h0000, cells_of(cell_count_select)};
            // Current halted on hot; no duration limit anywhere
            CHARGE_CURRENT_EN_OUT <= charging_next && !therm_hot;
            // Pause only the switching on overvoltage, no fault
            SWITCHING_EN_OUT <= (charging_next && !therm_hot && !battery_overvoltage_flag) ||
                (state_next == ST_CAL);
            DISCHARGE_EN_OUT <= (state_next == ST_CAL);
            CHARGE_ACTIVE_N_OUT <= !charging_next;
            STATUS_PIN_THREE_OUT <= 1'b0;
            if (pin3_mode_reg) begin
                STATUS_PIN_THREE_OE_OUT <= cal_done_next;
            end else begin
                STATUS_PIN_THREE_OE_OUT <= therm_hot && charging_next;
            end
        end
    end

    // Read data, one cycle after the strobe
    always @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            RDATA_OUT <= 16'h0000;
        end else if (RD_IN) begin
            case (ADDR_IN)
                `LACC_ADDR_BACKUP_CTRL: RDATA_OUT <= {14'h0000, zeroing_request_bit_reg,
                    charge_inhibit_reg};
                `LACC_ADDR_BACKUP_STAT: RDATA_OUT <= {13'h0000, discharge_test_fault_reg,
                    cal_done_reg, cal_on_reg};
                `LACC_ADDR_CHG_STAT: RDATA_OUT <= {8'h00, battery_overvoltage_flag,
                    battery_absent, alarm_inhibited_reg, charge_inhibited_reg,
                    state_reg == ST_FLOAT, state_reg == ST_BULK, charge_fault_bit_reg,
                    !CHARGE_ACTIVE_N_OUT};
                `LACC_ADDR_CHG_VOLT: RDATA_OUT <= chg_volt_reg;
                `LACC_ADDR_CHG_CURR: RDATA_OUT <= chg_curr_reg;
                `LACC_ADDR_CONFIG: RDATA_OUT <= {3'h0, pin3_mode_reg, cutoff_per_cell_reg};
                `LACC_ADDR_FLOAT: RDATA_OUT <= FLOAT_TARGET_MV_OUT;
                default: RDATA_OUT <= 16'h0000;
            endcase
        end else begin
            RDATA_OUT <= 16'h0000;
        end
    end
endmodule

`default_nettype wire
